// ==== dma_pair_regs.vh ====
`ifndef DMA_PAIR_REGS_VH
`define DMA_PAIR_REGS_VH
// register byte offsets (low 12 bits of the byte address)
`define OFF_RX_ADDR      12'h100
`define OFF_RX_COUNT     12'h104
`define OFF_TX_ADDR      12'h108
`define OFF_TX_COUNT     12'h10C
`define OFF_RX_NEXT_ADDR 12'h110
`define OFF_RX_NEXT_CNT  12'h114
`define OFF_TX_NEXT_ADDR 12'h118
`define OFF_TX_NEXT_CNT  12'h11C
`define OFF_CONTROL      12'h120
`define OFF_STATUS       12'h124
// control and status bit positions
`define BIT_RX_ON        0
`define BIT_RX_OFF       1
`define BIT_TX_ON        8
`define BIT_TX_OFF       9
// transfer size codes
`define SIZE_BYTE        2'h0
`define SIZE_HALF        2'h1
`define SIZE_WORD        2'h2
// reset values
`define RST_ADDR         32'h0000_0000
`define RST_COUNT        16'h0000
`endif

// ==== dma_pair.v ====
`timescale 1ns/1ps
`include "dma_pair_regs.vh"
module dma_pair #(
   parameter CNT_W = 16
) (
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [11:0] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // peripheral side
   input  wire        peripheral_rx_request_i,
   input  wire        peripheral_tx_request_i,
   input  wire [1:0]  xfer_size_i,
   output reg         rx_buffer_end_flag_o,
   output reg         rx_all_buffers_full_flag_o,
   output reg         tx_buffer_end_flag_o,
   output reg         tx_all_buffers_empty_flag_o,
   output reg         rx_grant_o,
   output reg         tx_grant_o,
   // memory side
   output reg         mem_req_o,
   output reg         mem_we_o,
   output reg  [31:0] mem_adr_o,
   output reg  [1:0]  mem_size_o,
   input  wire        mem_done_i
);

   localparam ST_IDLE = 2'h0;
   localparam ST_RX   = 2'h1;
   localparam ST_TX   = 2'h2;

   reg [31:0]      rx_address_field;
   reg [CNT_W-1:0] rx_count_field;
   reg [31:0]      tx_address_field;
   reg [CNT_W-1:0] tx_count_field;
   reg [31:0]      rx_chained_address_field;
   reg [CNT_W-1:0] rx_chained_count_field;
   reg [31:0]      tx_chained_address_field;
   reg [CNT_W-1:0] tx_chained_count_field;
   reg             rx_on_reg;
   reg             tx_on_reg;
   reg [1:0]       state_reg;
   reg [1:0]       size_reg;
   reg [31:0]      rd_next;
   reg [31:0]      step;

   wire        access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wr       = access & wb_we_i;
   wire [31:0] wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire        w_rx_a   = wr & (wb_adr_i == `OFF_RX_ADDR);
   wire        w_rx_c   = wr & (wb_adr_i == `OFF_RX_COUNT);
   wire        w_tx_a   = wr & (wb_adr_i == `OFF_TX_ADDR);
   wire        w_tx_c   = wr & (wb_adr_i == `OFF_TX_COUNT);
   wire        w_rxn_a  = wr & (wb_adr_i == `OFF_RX_NEXT_ADDR);
   wire        w_rxn_c  = wr & (wb_adr_i == `OFF_RX_NEXT_CNT);
   wire        w_txn_a  = wr & (wb_adr_i == `OFF_TX_NEXT_ADDR);
   wire        w_txn_c  = wr & (wb_adr_i == `OFF_TX_NEXT_CNT);
   wire        w_ctl    = wr & (wb_adr_i == `OFF_CONTROL);
   wire [31:0] wdat     = wb_dat_i & wmask;

   // transfer completes this cycle
   wire rx_done = (state_reg == ST_RX) & mem_done_i;
   wire tx_done = (state_reg == ST_TX) & mem_done_i;

   // masked merge of write data into a register
   function [31:0] merge;
      input [31:0] old;
      input [31:0] dat;
      input [31:0] msk;
      begin
         merge = (old & ~msk) | (dat & msk);
      end
   endfunction

   // merged counter writes, cut back to the counter width
   wire [31:0] rxc_merged  = merge({{(32-CNT_W){1'b0}}, rx_count_field}, wdat, wmask);
   wire [31:0] rxnc_merged = merge({{(32-CNT_W){1'b0}}, rx_chained_count_field}, wdat, wmask);
   wire [31:0] txc_merged  = merge({{(32-CNT_W){1'b0}}, tx_count_field}, wdat, wmask);
   wire [31:0] txnc_merged = merge({{(32-CNT_W){1'b0}}, tx_chained_count_field}, wdat, wmask);

   always @* begin
      case (size_reg)
         `SIZE_BYTE: step = 32'h0000_0001;
         `SIZE_HALF: step = 32'h0000_0002;
         default:    step = 32'h0000_0004;
      endcase
   end

   // register read mux
   always @* begin
      rd_next = 32'h0000_0000;
      case (wb_adr_i)
         `OFF_RX_ADDR:      rd_next = rx_address_field;
         `OFF_RX_COUNT:     rd_next = {{(32-CNT_W){1'b0}}, rx_count_field};
         `OFF_TX_ADDR:      rd_next = tx_address_field;
         `OFF_TX_COUNT:     rd_next = {{(32-CNT_W){1'b0}}, tx_count_field};
         `OFF_RX_NEXT_ADDR: rd_next = rx_chained_address_field;
         `OFF_RX_NEXT_CNT:  rd_next = {{(32-CNT_W){1'b0}}, rx_chained_count_field};
         `OFF_TX_NEXT_ADDR: rd_next = tx_chained_address_field;
         `OFF_TX_NEXT_CNT:  rd_next = {{(32-CNT_W){1'b0}}, tx_chained_count_field};
         `OFF_STATUS: begin
            rd_next[`BIT_RX_ON] = rx_on_reg;
            rd_next[`BIT_TX_ON] = tx_on_reg;
         end
         default:           rd_next = 32'h0000_0000; // control is write-only
      endcase
   end

   // wishbone ack and read data, one-cycle answer
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= access;
         wb_dat_o <= (access & ~wb_we_i) ? rd_next : 32'h0000_0000;
      end
   end

   // enable bits, disable wins
   always @(posedge clk_i) begin
      if (rst_i) begin
         rx_on_reg <= 1'b0;
         tx_on_reg <= 1'b0;
      end else if (w_ctl) begin
         if (wb_sel_i[0] & wb_dat_i[`BIT_RX_OFF])
            rx_on_reg <= 1'b0;
         else if (wb_sel_i[0] & wb_dat_i[`BIT_RX_ON])
            rx_on_reg <= 1'b1;
         if (wb_sel_i[1] & wb_dat_i[`BIT_TX_OFF])
            tx_on_reg <= 1'b0;
         else if (wb_sel_i[1] & wb_dat_i[`BIT_TX_ON])
            tx_on_reg <= 1'b1;
      end
   end

   // receive channel pointers and counters
   always @(posedge clk_i) begin
      if (rst_i) begin
         rx_address_field         <= `RST_ADDR;
         rx_count_field           <= `RST_COUNT;
         rx_chained_address_field <= `RST_ADDR;
         rx_chained_count_field   <= `RST_COUNT;
      end else begin
         if (rx_done) begin
            if ((rx_count_field == 1) && (rx_chained_count_field != 0)) begin
               rx_address_field       <= rx_chained_address_field;
               rx_count_field         <= rx_chained_count_field;
               rx_chained_count_field <= `RST_COUNT;
            end else begin
               rx_address_field <= rx_address_field + step;
               rx_count_field   <= rx_count_field - 1'b1;
            end
         end
         if (w_rx_a)
            rx_address_field <= merge(rx_address_field, wdat, wmask);
         if (w_rx_c)
            rx_count_field <= rxc_merged[CNT_W-1:0];
         if (w_rxn_a)
            rx_chained_address_field <= merge(rx_chained_address_field, wdat, wmask);
         if (w_rxn_c)
            rx_chained_count_field <= rxnc_merged[CNT_W-1:0];
      end
   end

   // transmit channel pointers and counters
   always @(posedge clk_i) begin
      if (rst_i) begin
         tx_address_field         <= `RST_ADDR;
         tx_count_field           <= `RST_COUNT;
         tx_chained_address_field <= `RST_ADDR;
         tx_chained_count_field   <= `RST_COUNT;
      end else begin
         if (tx_done) begin
            if ((tx_count_field == 1) && (tx_chained_count_field != 0)) begin
               tx_address_field       <= tx_chained_address_field;
               tx_count_field         <= tx_chained_count_field;
               tx_chained_count_field <= `RST_COUNT;
            end else begin
               tx_address_field <= tx_address_field + step;
               tx_count_field   <= tx_count_field - 1'b1;
            end
         end
         if (w_tx_a)
            tx_address_field <= merge(tx_address_field, wdat, wmask);
         if (w_tx_c)
            tx_count_field <= txc_merged[CNT_W-1:0];
         if (w_txn_a)
            tx_chained_address_field <= merge(tx_chained_address_field, wdat, wmask);
         if (w_txn_c)
            tx_chained_count_field <= txnc_merged[CNT_W-1:0];
      end
   end

   // request arbiter and memory handshake
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_reg  <= ST_IDLE;
         size_reg   <= `SIZE_BYTE;
         mem_req_o  <= 1'b0;
         mem_we_o   <= 1'b0;
         mem_adr_o  <= 32'h0000_0000;
         mem_size_o <= `SIZE_BYTE;
         rx_grant_o <= 1'b0;
         tx_grant_o <= 1'b0;
      end else begin
         rx_grant_o <= 1'b0;
         tx_grant_o <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (peripheral_rx_request_i & rx_on_reg & (rx_count_field != 0)) begin
                  state_reg  <= ST_RX;
                  size_reg   <= xfer_size_i;
                  mem_req_o  <= 1'b1;
                  mem_we_o   <= 1'b1;
                  mem_adr_o  <= rx_address_field;
                  mem_size_o <= xfer_size_i;
               end else if (peripheral_tx_request_i & tx_on_reg & (tx_count_field != 0)) begin
                  state_reg  <= ST_TX;
                  size_reg   <= xfer_size_i;
                  mem_req_o  <= 1'b1;
                  mem_we_o   <= 1'b0;
                  mem_adr_o  <= tx_address_field;
                  mem_size_o <= xfer_size_i;
               end
            end
            ST_RX, ST_TX: begin
               if (mem_done_i) begin
                  state_reg  <= ST_IDLE;
                  mem_req_o  <= 1'b0;
                  rx_grant_o <= (state_reg == ST_RX);
                  tx_grant_o <= (state_reg == ST_TX);
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // end and buffer flags, count writes clear the end flag
   always @(posedge clk_i) begin
      if (rst_i) begin
         rx_buffer_end_flag_o        <= 1'b0;
         rx_all_buffers_full_flag_o  <= 1'b0;
         tx_buffer_end_flag_o        <= 1'b0;
         tx_all_buffers_empty_flag_o <= 1'b0;
      end else begin
         if (rx_done & (rx_count_field == 1))
            rx_buffer_end_flag_o <= 1'b1;
         else if (w_rx_c | w_rxn_c)
            rx_buffer_end_flag_o <= 1'b0;
         if (tx_done & (tx_count_field == 1))
            tx_buffer_end_flag_o <= 1'b1;
         else if (w_tx_c | w_txn_c)
            tx_buffer_end_flag_o <= 1'b0;
         rx_all_buffers_full_flag_o  <= (rx_count_field == 0) & (rx_chained_count_field == 0);
         tx_all_buffers_empty_flag_o <= (tx_count_field == 0) & (tx_chained_count_field == 0);
      end
   end

endmodule // dma_pair

// ==== dma_pair_properties.sv ====
`timescale 1ns/1ps
module dma_pair_properties #(
   parameter CNT_W = 16
) (
   input wire        clk_i,
   input wire        rst_i,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [11:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        rx_grant_o,
   input wire        tx_grant_o,
   input wire        mem_req_o,
   input wire        mem_we_o,
   input wire [31:0] mem_adr_o,
   input wire        mem_done_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   a_ack_after_take: assert property (take |=> wb_ack_o) else $error("no ack");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not zero");
   a_ctrl_read_zero: assert property (take && !wb_we_i && wb_adr_i == 12'h120 |=> wb_dat_o == 32'h0)
      else $error("control readable");
   a_req_holds_steady: assert property (mem_req_o && !mem_done_i |=>
      mem_req_o && $stable(mem_adr_o) && $stable(mem_we_o)) else $error("request moved");
   a_rx_done_grant: assert property (mem_req_o && mem_done_i && mem_we_o |=>
      rx_grant_o && !tx_grant_o && !mem_req_o) else $error("rx grant wrong");
   a_tx_done_grant: assert property (mem_req_o && mem_done_i && !mem_we_o |=>
      tx_grant_o && !rx_grant_o && !mem_req_o) else $error("tx grant wrong");
   a_grant_needs_done: assert property (rx_grant_o || tx_grant_o |-> $past(mem_done_i))
      else $error("grant without done");
   c_rx_move: cover property (rx_grant_o);
   c_tx_move: cover property (tx_grant_o);
   c_ctrl_write: cover property (take && wb_we_i && wb_adr_i == 12'h120);
endmodule // dma_pair_properties
bind dma_pair dma_pair_properties #(.CNT_W(CNT_W)) dma_pair_properties_i (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .rx_grant_o, .tx_grant_o, .mem_req_o,
   .mem_we_o, .mem_adr_o, .mem_done_i);

// ==== mem_partner.sv ====
`timescale 1ns/1ps
module mem_partner (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       mem_req_i,
   input  wire [3:0] wait_i,
   output reg        mem_done_o
);
   reg [3:0] wait_reg;
   // done pulse after wait_i idle cycles
   always @(posedge clk_i) begin
      if (rst_i || mem_done_o || !mem_req_i) begin
         mem_done_o <= 1'b0;
         wait_reg   <= 4'h0;
      end else if (wait_reg == wait_i) begin
         mem_done_o <= 1'b1;
      end else begin
         wait_reg <= wait_reg + 4'h1;
      end
   end
endmodule // mem_partner

// ==== dma_pair_tb.sv ====
`timescale 1ns/1ps
module dma_pair_tb;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         cyc = 1'b0;
   reg         we = 1'b0;
   reg  [11:0] adr = 12'h000;
   reg  [31:0] wdat = 32'h0;
   reg         rx_req = 1'b0;
   reg         tx_req = 1'b0;
   reg  [1:0]  size = 2'h2;
   reg  [3:0]  lat = 4'h0;
   reg  [31:0] q, e;
   reg  [11:0] o;
   wire [31:0] rdat, madr;
   wire [1:0]  msize;
   wire        ack, rx_end, rx_full, tx_end, tx_empty, rx_gnt, tx_gnt, mreq, mwe, done;
   integer     fails = 0;
   integer     tests_run = 0;
   integer     i;
   always #5 clk_i = ~clk_i;
   dma_pair dma_pair_i (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .peripheral_rx_request_i(rx_req),
      .peripheral_tx_request_i(tx_req), .xfer_size_i(size), .rx_buffer_end_flag_o(rx_end),
      .rx_all_buffers_full_flag_o(rx_full), .tx_buffer_end_flag_o(tx_end),
      .tx_all_buffers_empty_flag_o(tx_empty), .rx_grant_o(rx_gnt), .tx_grant_o(tx_gnt), .mem_req_o(mreq),
      .mem_we_o(mwe), .mem_adr_o(madr), .mem_size_o(msize), .mem_done_i(done));
   mem_partner mem_partner_i (.clk_i, .rst_i, .mem_req_i(mreq), .wait_i(lat), .mem_done_o(done));
   task chk(input [31:0] got, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task chkb(input got, input exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   task bus(input w, input [11:0] a, input [31:0] d);
      integer n;
      begin
         n = 0;
         @(posedge clk_i);
         cyc  <= 1'b1;
         we   <= w;
         adr  <= a;
         wdat <= d;
         @(posedge clk_i);
         while (ack !== 1'b1 && n < 20) begin
            n = n + 1;
            @(posedge clk_i);
         end
         if (n == 20) fails = fails + 1;
         q = rdat;
         cyc <= 1'b0;
         we  <= 1'b0;
      end
   endtask
   task rd(input [11:0] a, input [31:0] x);
      begin
         bus(1'b0, a, 32'h0);
         chk(q, x);
      end
   endtask
   task ctl(input [31:0] d, input [31:0] x);
      begin
         bus(1'b1, 12'h120, d);
         rd(12'h124, x);
      end
   endtask
   task xfer(input [31:0] a, input w);
      integer n;
      begin
         n = 0;
         while (mreq !== 1'b1 && n < 50) begin
            n = n + 1;
            @(posedge clk_i);
         end
         chk(madr, a);
         chkb(mwe, w);
         chk({30'h0, msize}, {30'h0, size});
         while (rx_gnt !== 1'b1 && tx_gnt !== 1'b1 && n < 100) begin
            n = n + 1;
            @(posedge clk_i);
         end
         if (n >= 100) fails = fails + 1;
      end
   endtask
   task wrap_up;
      begin
         $display("tests_run %0d fails %0d", tests_run, fails);
         if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
         end else begin
            $display("== FAILED ==");
         end
         $finish;
      end
   endtask
   initial begin
      #200000;
      fails = fails + 1;
      wrap_up;
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      for (o = 12'h100; o < 12'h12C; o = o + 12'h4) begin
         rd(o, 32'h0);
      end
      for (o = 12'h100; o < 12'h120; o = o + 12'h4) begin
         e = 32'hFFFF_5A3C ^ {20'h0, o};
         bus(1'b1, o, e);
         if (o[2]) e[31:16] = 16'h0;
         rd(o, e);
         bus(1'b1, o, 32'h0);
      end
      ctl(32'h0000_0003, 32'h0);
      ctl(32'h0000_0001, 32'h1);
      ctl(32'h0000_0000, 32'h1);
      ctl(32'h0000_0300, 32'h1);
      ctl(32'h0000_0100, 32'h101);
      rd(12'h120, 32'h0);
      ctl(32'h0000_0200, 32'h1);
      ctl(32'h0000_0002, 32'h0);
      rx_req <= 1'b1;
      bus(1'b1, 12'h104, 32'h1);
      repeat (10) @(posedge clk_i);
      chkb(mreq, 1'b0);
      bus(1'b1, 12'h100, 32'h0000_1000);
      bus(1'b1, 12'h110, 32'h0000_2000);
      bus(1'b1, 12'h114, 32'h1);
      bus(1'b1, 12'h104, 32'h2);
      rx_req <= 1'b0;
      ctl(32'h0000_0001, 32'h1);
      rx_req <= 1'b1;
      xfer(32'h0000_1000, 1'b1);
      xfer(32'h0000_1004, 1'b1);
      xfer(32'h0000_2000, 1'b1);
      rd(12'h100, 32'h0000_2004);
      rd(12'h104, 32'h0);
      rd(12'h114, 32'h0);
      chkb(rx_end, 1'b1);
      chkb(rx_full, 1'b1);
      bus(1'b1, 12'h104, 32'h0);
      rd(12'h124, 32'h1);
      chkb(rx_end, 1'b0);
      lat <= 4'h3;
      tx_req <= 1'b1;
      ctl(32'h0000_0100, 32'h101);
      for (i = 0; i < 3; i = i + 1) begin
         size <= i[1:0];
         bus(1'b1, 12'h108, 32'h0000_0040);
         bus(1'b1, 12'h10C, 32'h1);
         xfer(32'h0000_0040, 1'b0);
         rd(12'h108, 32'h0000_0040 + (32'h1 << i));
      end
      repeat (8) @(posedge clk_i);
      chkb(mreq, 1'b0);
      chkb(tx_end, 1'b1);
      chkb(tx_empty, 1'b1);
      rx_req <= 1'b0;
      tx_req <= 1'b0;
      bus(1'b1, 12'h104, 32'h1);
      bus(1'b1, 12'h10C, 32'h1);
      rx_req <= 1'b1;
      tx_req <= 1'b1;
      xfer(32'h0000_2004, 1'b1);
      xfer(32'h0000_0044, 1'b0);
      wrap_up;
   end
endmodule // dma_pair_tb
